/* File: include/pb_seq_defs.svh */
`ifndef PB_SEQ_DEFS_SVH
`define PB_SEQ_DEFS_SVH
// Clock rate and the time base tick.
`define CLK_HZ 25000000
`define TICK_US 1000
`define TICK_CYCLES (`CLK_HZ / 1000000 * `TICK_US)
// Durations in milliseconds.
`define ON_DEBOUNCE_MS 128
`define BLANK_MS 512
`define OFF_DEBOUNCE_MS 32
`define RELEASE_DEBOUNCE_MS 32
`define FAILSAFE_MS 128
`define LOCKOUT_MS 256
// Least low time of the shutdown request, in microseconds.
`define SHDN_FILTER_US 30
`define SHDN_FILTER_CYCLES ((`SHDN_FILTER_US * `CLK_HZ + 999999) / 1000000)
// Width of the millisecond counters.
`define MS_W 16
`endif

/* File: include/pb_seq_pkg.sv */
`default_nettype none
package pb_seq_pkg;
    typedef enum logic [7:0] {
        ST_IDLE = 8'h01,
        ST_ON_DEB = 8'h02,
        ST_BLANK = 8'h04,
        ST_REL_DEB = 8'h08,
        ST_RUN = 8'h10,
        ST_OFF_DEB = 8'h20,
        ST_FAILSAFE = 8'h40,
        ST_LOCKOUT = 8'h80
    } seq_state_t;
    typedef struct packed {
        logic [15:0] off_extend_ms;
        logic [15:0] failsafe_extend_ms;
    } ext_cfg_t;
    typedef struct packed {
        logic power_enable;
        logic host_alert_n;
    } seq_out_t;
endpackage
`default_nettype wire

/* File: core/tick_gen.sv */
`include "pb_seq_defs.svh"
`default_nettype none
module tick_gen
    import pb_seq_pkg::*;
#(
    parameter int TICK_LEN = `TICK_CYCLES
)
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // One-cycle pulse per millisecond.
    output logic tick
);
    typedef struct packed {
        logic [15:0] cnt;
        logic tick;
    } tick_st_t;
    localparam logic [15:0] TICK_LAST = 16'(TICK_LEN - 1);
    tick_st_t st_ff;
    tick_st_t nxt_st;
    always_comb begin
        nxt_st = st_ff;
        nxt_st.tick = 1'b0;
        if (st_ff.cnt == TICK_LAST) begin
            nxt_st.cnt = 16'h0000;
            nxt_st.tick = 1'b1;
        end else begin
            nxt_st.cnt = st_ff.cnt + 16'h0001;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end
    assign tick = st_ff.tick;
endmodule // tick_gen
`default_nettype wire

/* File: core/pb_seq.sv */
// Function
// - At reset power enable is off and the converter stays off.
// - Turn on after pushbutton held low 128 ms; a high restarts count.
// - After enable, blank pushbutton and shutdown request for 512 ms.
// - Shutdown request still low at blanking end drops power enable.
// - After blanking, debounce button release for 32 ms before monitoring.
// - Turn-off needs button low 32 ms plus extension; high restarts.
// - Turn-off extension is configurable; zero extension gives 32 ms.
// - Valid turn-off debounce drives host alert low.
// - Failsafe 128 ms from alert; expiry drops enable.
// - Failsafe period extends by a configurable extra time.
// - Shutdown request low in failsafe drops enable at once.
// - Running, shutdown request low drops enable at once.
// - After power-off, debounce button release 32 ms before idle.
// - After a filtered shutdown request drops enable, ignore pushbutton for 256 ms.
// - Idle waits for a falling pushbutton edge to start power-on.
// - Parameter selects power enable polarity; timing is identical.
// - Shutdown request low acts only after persisting 30 us, except the unfiltered check at blanking end.
// - Lockout excludes on-debounce; fresh 128 ms debounce follows.
`include "pb_seq_defs.svh"
`default_nettype none
module pb_seq
    import pb_seq_pkg::*;
#(
    parameter bit ENABLE_ACTIVE_HIGH = 1'b1,
    // Tick and request filter lengths in clocks; shorten them only to speed up a run.
    parameter int TICK_LEN = `TICK_CYCLES,
    parameter int SD_FILT_LEN = `SHDN_FILTER_CYCLES
)
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Pins from outside.
    input wire logic pushbutton_n,
    input wire logic shutdown_request_n,
    // Timer extensions in milliseconds.
    input wire ext_cfg_t ext_cfg,
    // Outputs.
    output logic power_enable,
    output logic host_alert_n
);
    typedef struct packed {
        logic [1:0] pb_sync;
        logic [1:0] sd_sync;
        logic pb_prev;
        logic [9:0] sd_low_cnt;
        logic sd_low;
        logic [`MS_W-1:0] ms_cnt;
        seq_state_t state;
        logic en_on;
        logic alert_n;
    } seq_st_t;
    localparam logic [9:0] SD_FILT = 10'(SD_FILT_LEN);
    localparam logic [`MS_W-1:0] ON_MS = `MS_W'(`ON_DEBOUNCE_MS);
    localparam logic [`MS_W-1:0] BLANK_T = `MS_W'(`BLANK_MS);
    localparam logic [`MS_W-1:0] REL_T = `MS_W'(`RELEASE_DEBOUNCE_MS);
    localparam logic [`MS_W-1:0] OFF_T = `MS_W'(`OFF_DEBOUNCE_MS);
    localparam logic [`MS_W-1:0] FS_T = `MS_W'(`FAILSAFE_MS);
    localparam logic [`MS_W-1:0] LOCK_T = `MS_W'(`LOCKOUT_MS);
    seq_st_t st_ff;
    seq_st_t nxt_st;
    logic tick;
    logic pb_low;
    logic [`MS_W:0] off_limit;
    logic [`MS_W:0] fs_limit;
    tick_gen #(.TICK_LEN(TICK_LEN)) u_tick (
        .clk(clk),
        .rst_n(rst_n),
        .tick(tick)
    );
    // True once the counter has passed the duration, so tick phase never makes a timer short.
    function automatic logic reached(input logic [`MS_W-1:0] cnt, input logic [`MS_W:0] lim);
        reached = ({1'b0, cnt} > lim);
    endfunction
    assign pb_low = ~st_ff.pb_sync[1];
    assign off_limit = {1'b0, OFF_T} + {1'b0, ext_cfg.off_extend_ms};
    assign fs_limit = {1'b0, FS_T} + {1'b0, ext_cfg.failsafe_extend_ms};
    always_comb begin
        nxt_st = st_ff;
        nxt_st.pb_sync = {st_ff.pb_sync[0], pushbutton_n};
        nxt_st.sd_sync = {st_ff.sd_sync[0], shutdown_request_n};
        nxt_st.pb_prev = st_ff.pb_sync[1];
        // Short low glitches on the request are filtered out.
        if (st_ff.sd_sync[1]) begin
            nxt_st.sd_low_cnt = 10'h000;
            nxt_st.sd_low = 1'b0;
        end else if (st_ff.sd_low_cnt >= SD_FILT - 10'h001) begin
            nxt_st.sd_low = 1'b1;
        end else begin
            nxt_st.sd_low_cnt = st_ff.sd_low_cnt + 10'h001;
        end
        if (tick) begin
            nxt_st.ms_cnt = st_ff.ms_cnt + `MS_W'(1);
        end
        case (st_ff.state)
            ST_IDLE: begin
                nxt_st.en_on = 1'b0;
                nxt_st.alert_n = 1'b1;
                nxt_st.ms_cnt = '0;
                if (st_ff.pb_prev && pb_low) begin
                    nxt_st.state = ST_ON_DEB;
                end
            end
            ST_ON_DEB: begin
                if (!pb_low) begin
                    nxt_st.state = ST_IDLE;
                end else if (reached(st_ff.ms_cnt, {1'b0, ON_MS})) begin
                    nxt_st.state = ST_BLANK;
                    nxt_st.en_on = 1'b1;
                    nxt_st.ms_cnt = '0;
                end
            end
            ST_BLANK: begin
                // Inputs are not looked at until the window ends.
                if (reached(st_ff.ms_cnt, {1'b0, BLANK_T})) begin
                    nxt_st.ms_cnt = '0;
                    if (!st_ff.sd_sync[1]) begin
                        nxt_st.en_on = 1'b0;
                        nxt_st.state = ST_REL_DEB;
                    end else begin
                        nxt_st.state = ST_REL_DEB;
                    end
                end
            end
            ST_REL_DEB: begin
                // Shared release debounce: after power-on it leads to run, after off to idle.
                if (pb_low) begin
                    nxt_st.ms_cnt = '0;
                end else if (reached(st_ff.ms_cnt, {1'b0, REL_T})) begin
                    nxt_st.ms_cnt = '0;
                    nxt_st.state = st_ff.en_on ? ST_RUN : ST_IDLE;
                end
                if (st_ff.en_on && st_ff.sd_low) begin
                    nxt_st.en_on = 1'b0;
                    nxt_st.ms_cnt = '0;
                    nxt_st.state = ST_LOCKOUT;
                end
            end
            ST_RUN: begin
                nxt_st.ms_cnt = '0;
                if (st_ff.sd_low) begin
                    nxt_st.en_on = 1'b0;
                    nxt_st.state = ST_LOCKOUT;
                end else if (pb_low) begin
                    nxt_st.state = ST_OFF_DEB;
                end
            end
            ST_OFF_DEB: begin
                if (st_ff.sd_low) begin
                    nxt_st.en_on = 1'b0;
                    nxt_st.ms_cnt = '0;
                    nxt_st.state = ST_LOCKOUT;
                end else if (!pb_low) begin
                    nxt_st.state = ST_RUN;
                end else if (reached(st_ff.ms_cnt, off_limit)) begin
                    nxt_st.alert_n = 1'b0;
                    nxt_st.ms_cnt = '0;
                    nxt_st.state = ST_FAILSAFE;
                end
            end
            ST_FAILSAFE: begin
                if (st_ff.sd_low) begin
                    nxt_st.en_on = 1'b0;
                    nxt_st.ms_cnt = '0;
                    nxt_st.state = ST_LOCKOUT;
                end else if (reached(st_ff.ms_cnt, fs_limit)) begin
                    nxt_st.en_on = 1'b0;
                    nxt_st.ms_cnt = '0;
                    nxt_st.state = ST_REL_DEB;
                end
            end
            ST_LOCKOUT: begin
                // Supply decays here; the button cannot restart it early.
                if (reached(st_ff.ms_cnt, {1'b0, LOCK_T})) begin
                    nxt_st.ms_cnt = '0;
                    nxt_st.state = ST_REL_DEB;
                end
            end
            default: begin
                nxt_st.state = ST_IDLE;
                nxt_st.en_on = 1'b0;
            end
        endcase
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '{pb_sync: 2'b11, sd_sync: 2'b11, pb_prev: 1'b1, sd_low_cnt: 10'h000,
                       sd_low: 1'b0, ms_cnt: '0, state: ST_IDLE, en_on: 1'b0,
                       alert_n: 1'b1};
        end else begin
            st_ff <= nxt_st;
        end
    end
    // Polarity applies only at the pin, so both variants share all timing.
    seq_out_t out_ff;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_ff <= '{power_enable: ~ENABLE_ACTIVE_HIGH, host_alert_n: 1'b1};
        end else begin
            out_ff.power_enable <= nxt_st.en_on ~^ ENABLE_ACTIVE_HIGH;
            out_ff.host_alert_n <= nxt_st.alert_n | ~nxt_st.en_on;
        end
    end
    assign power_enable = out_ff.power_enable;
    assign host_alert_n = out_ff.host_alert_n;
endmodule // pb_seq
`default_nettype wire

/* File: sim/pb_seq_monitor.sv */
`default_nettype none
module pb_seq_monitor
    import pb_seq_pkg::*;
#(
    parameter bit ENABLE_ACTIVE_HIGH = 1'b1,
    parameter int MS = 25000,
    parameter int FILT = 750
)
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Watched ports.
    input wire logic pushbutton_n,
    input wire logic shutdown_request_n,
    input wire ext_cfg_t ext_cfg,
    input wire logic power_enable,
    input wire logic host_alert_n
);
    timeunit 1ns;
    timeprecision 1ns;
    logic en;
    int unsigned pb_lo_ff, sd_lo_ff, en_cnt_ff, al_cnt_ff;
    assign en = (power_enable == ENABLE_ACTIVE_HIGH);
    // Counters of unbroken levels, so every timer but release debounce and lockout is judged against its cause.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pb_lo_ff <= 0;
            sd_lo_ff <= 0;
            en_cnt_ff <= 0;
            al_cnt_ff <= 0;
        end else begin
            pb_lo_ff <= pushbutton_n ? 0 : pb_lo_ff + 1;
            sd_lo_ff <= shutdown_request_n ? 0 : sd_lo_ff + 1;
            en_cnt_ff <= en ? en_cnt_ff + 1 : 0;
            al_cnt_ff <= host_alert_n ? 0 : al_cnt_ff + 1;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    chk_reset_off: assert property (disable iff (1'b0) !rst_n |-> !en && host_alert_n)
        else $error("outputs active in reset");
    chk_alert_needs_en: assert property (!host_alert_n |-> en)
        else $error("alert without enable");
    chk_on_debounce: assert property ($rose(en) |-> pb_lo_ff >= 128 * MS)
        else $error("enable before on debounce");
    chk_blank_hold: assert property ($fell(en) |-> en_cnt_ff >= 511 * MS)
        else $error("enable dropped in blanking");
    chk_abort_end: assert property (en_cnt_ff == 514 * MS |-> sd_lo_ff < 3 * MS)
        else $error("no abort at blanking end");
    chk_kill_fast: assert property (sd_lo_ff == FILT + 8 |-> !en || en_cnt_ff < 514 * MS + FILT + 8)
        else $error("shutdown request ignored");
    chk_kill_filter: assert property ($fell(en) && $past(host_alert_n) && en_cnt_ff > 514 * MS
        |-> sd_lo_ff >= FILT)
        else $error("short shutdown pulse acted on");
    chk_alert_debounce: assert property ($fell(host_alert_n)
        |-> pb_lo_ff >= (32 + ext_cfg.off_extend_ms) * MS)
        else $error("alert before off debounce");
    chk_failsafe_min: assert property ($fell(en) && !$past(host_alert_n)
        |-> sd_lo_ff >= FILT || al_cnt_ff >= (127 + ext_cfg.failsafe_extend_ms) * MS)
        else $error("failsafe expired early");
    chk_failsafe_max: assert property (!host_alert_n
        |-> al_cnt_ff < (130 + ext_cfg.failsafe_extend_ms) * MS)
        else $error("failsafe never expired");
endmodule // pb_seq_monitor
bind pb_seq pb_seq_monitor #(.ENABLE_ACTIVE_HIGH(ENABLE_ACTIVE_HIGH), .MS(TICK_LEN),
    .FILT(SD_FILT_LEN)) pb_seq_monitor_i (
    .clk(clk), .rst_n(rst_n), .pushbutton_n(pushbutton_n),
    .shutdown_request_n(shutdown_request_n), .ext_cfg(ext_cfg),
    .power_enable(power_enable), .host_alert_n(host_alert_n));
`default_nettype wire

/* File: sim/host_model.sv */
`default_nettype none
module host_model
#(
    parameter int MS = 25000
)
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Supply and behaviour: 0 boots, 1 never boots, 3 pulls the request low.
    input wire logic power_on,
    input wire logic [1:0] mode,
    output logic shutdown_request_n
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int BOOT = 50 * MS;
    int unsigned cnt_ff;
    // An unpowered host holds its output low, as a real one would.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= 0;
            shutdown_request_n <= 1'b0;
        end else if (!power_on) begin
            cnt_ff <= 0;
            shutdown_request_n <= 1'b0;
        end else if (mode == 2'h3) begin
            shutdown_request_n <= 1'b0;
        end else if (cnt_ff < BOOT) begin
            cnt_ff <= cnt_ff + 1;
        end else begin
            shutdown_request_n <= (mode != 2'h1);
        end
    end
endmodule // host_model
`default_nettype wire

/* File: sim/pb_seq_tb.sv */
`default_nettype none
module pb_seq_tb
    import pb_seq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // A shortened time base keeps the run short; every millisecond duration still counts in ticks.
    localparam int MS = 25;
    localparam int FILT = 12;
    logic clk = 1'b0, rst_n = 1'b1, pushbutton_n = 1'b1;
    logic [1:0] mode = 2'h1;
    ext_cfg_t ext_cfg;
    logic shutdown_request_n, power_enable, host_alert_n, enable_lo;
    int error_cnt = 0, check_count = 0;
    int unsigned seed;
    always #20 clk = ~clk;
    pb_seq #(.TICK_LEN(MS), .SD_FILT_LEN(FILT)) pb_seq_i (.clk(clk), .rst_n(rst_n),
        .pushbutton_n(pushbutton_n),
        .shutdown_request_n(shutdown_request_n), .ext_cfg(ext_cfg),
        .power_enable(power_enable), .host_alert_n(host_alert_n));
    pb_seq #(.ENABLE_ACTIVE_HIGH(1'b0), .TICK_LEN(MS), .SD_FILT_LEN(FILT)) pb_seq_lo_i (
        .clk(clk), .rst_n(rst_n),
        .pushbutton_n(pushbutton_n), .shutdown_request_n(shutdown_request_n),
        .ext_cfg(ext_cfg), .power_enable(enable_lo), .host_alert_n());
    host_model #(.MS(MS)) host_model_i (.clk(clk), .rst_n(rst_n), .power_on(power_enable),
        .mode(mode), .shutdown_request_n(shutdown_request_n));
    task automatic report_and_stop;
        if (error_cnt == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Both polarity variants are compared at once, since their timing must match.
    task automatic check_out(input logic en, input logic al);
        #1;
        check_count++;
        if (power_enable !== en || enable_lo !== ~en || host_alert_n !== al) begin
            error_cnt++;
            $display("ERROR %0t en %h exp %h alert %h exp %h", $time, power_enable, en,
                host_alert_n, al);
        end
        @(posedge clk);
    endtask
    task automatic ms(input int n);
        repeat (n * MS) @(posedge clk);
    endtask
    // A bounced press, then a full press released about 20 ms into blanking.
    task automatic power_up(input logic [1:0] m);
        mode <= m;
        pushbutton_n <= 1'b0;
        ms(1 + $urandom % 60);
        pushbutton_n <= 1'b1;
        ms(2);
        check_out(1'b0, 1'b1);
        pushbutton_n <= 1'b0;
        ms(127);
        check_out(1'b0, 1'b1);
        ms(3);
        check_out(1'b1, 1'b1);
        ms(20);
        pushbutton_n <= 1'b1;
        ms(489);
        check_out(1'b1, 1'b1);
    endtask
    initial begin
        rst_n <= 1'b0;
        seed = $urandom(32'h0C9F);
        ext_cfg.off_extend_ms = 16'($urandom % 4);
        ext_cfg.failsafe_extend_ms = 16'($urandom % 4);
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        check_out(1'b0, 1'b1);
        power_up(2'h1);
        ms(4);
        check_out(1'b0, 1'b1);
        ms(40);
        power_up(2'h0);
        ms(40);
        check_out(1'b1, 1'b1);
        mode <= 2'h3;
        repeat (FILT / 2) @(posedge clk);
        mode <= 2'h0;
        ms(1);
        check_out(1'b1, 1'b1);
        pushbutton_n <= 1'b0;
        ms(20);
        pushbutton_n <= 1'b1;
        ms(1);
        pushbutton_n <= 1'b0;
        ms(31 + ext_cfg.off_extend_ms);
        check_out(1'b1, 1'b1);
        ms(3);
        check_out(1'b1, 1'b0);
        pushbutton_n <= 1'b1;
        ms(125 + ext_cfg.failsafe_extend_ms);
        check_out(1'b1, 1'b0);
        ms(5);
        check_out(1'b0, 1'b1);
        ms(40);
        power_up(2'h0);
        ms(36);
        mode <= 2'h3;
        ms(1);
        check_out(1'b0, 1'b1);
        pushbutton_n <= 1'b0;
        ms(200);
        pushbutton_n <= 1'b1;
        ms(110);
        check_out(1'b0, 1'b1);
        power_up(2'h0);
        report_and_stop();
    end
endmodule // pb_seq_tb
`default_nettype wire
